// *** hw/lane_8b10b_mode_config.sv ***
// controller that programs and verifies one transceiver lane for 8b10b mode
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
module lane_8b10b_mode_config (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_dev_req,
    output logic o_dev_write,
    output logic [2:0] o_dev_addr,
    output logic [31:0] o_dev_wdata,
    input wire logic [31:0] i_dev_rdata,
    input wire logic i_dev_ack
);
    import lane_cfg_pkg::*;

    logic [lane_cfg_pkg::CFG_WIDTH-1:0] config_reg;
    seq_state_t state;
    logic [2:0] idx;
    logic done;
    logic mismatch;
    logic violation;
    logic [DEV_REGS-1:0] fail_mask;
    logic check_ok;
    logic start_cmd;
    logic wr_take;

    wire logic [1:0] gear = config_reg[CFG_GEAR_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // expected device word per index; the same word is written and later compared
    function automatic logic [31:0] dev_word(input logic [2:0] index, input logic [10:0] cfg);
        logic [31:0] w;
        w = 32'h0;
        case (index)
            DEV_ENCODER_LANE_CONFIG: w[GEAR_LSB +: 2] = cfg[CFG_GEAR_LSB +: 2];
            DEV_LANE_OVERLAY_PATH_SELECT: begin
                w[FABRIC_PATH_LSB +: 4] = FABRIC_PATH_8B10B;
                w[SERLANE_PATH_LSB +: 4] = cfg[CFG_SERPATH_LSB +: 4];
            end
            DEV_LANE_CLOCK_SOURCE_SELECT: begin
                w[FAB_RX_CLK_LSB +: 2] = cfg[CFG_FAB_RX_LSB +: 2];
                w[FAB_TX_CLK_LSB +: 2] = cfg[CFG_FAB_TX_LSB +: 2];
                w[CODING_RX_SRC_LSB +: 2] = CODING_CLK_SRC;
                w[CODING_TX_SRC_LSB +: 2] = CODING_CLK_SRC;
                w[RXF_WR_SRC_LSB +: 2] = cfg[CFG_GEAR_LSB +: 2];
                w[TXF_RD_SRC_LSB +: 2] = cfg[CFG_GEAR_LSB +: 2];
                w[RXF_SIDE_BIT] = RXF_SIDE_8B10B;
            end
            DEV_LANE_CLOCK_ENABLES: w[3:0] = CLOCK_ENABLES_ALL;
            DEV_DESERIALIZER_WIDTH_CONTROL,
            DEV_SERIALIZER_WIDTH_CONTROL: w[WIDTH_LSB +: 3] = WIDTH_40BIT;
            DEV_RECOVERY_SLIP_CONTROL: begin
                w[SLIP_SRC_BIT] = SLIP_SRC_FABRIC;
                w[SLIP_EN_BIT] = SLIP_EN_ON;
            end
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: waitrequest drops for one cycle, one cycle after the request appears
    assign wr_take = i_write && !o_waitrequest;
    assign start_cmd = wr_take && i_address == CTRL_OFFSET && i_byteenable[0]
        && i_writedata[CTRL_START_BIT] && state == ST_IDLE;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_waitrequest <= 1'b1;
        end else if (!o_waitrequest) begin
            o_waitrequest <= 1'b1;
        end else if (i_read || i_write) begin
            o_waitrequest <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_readdata <= 32'h0;
        end else if (i_read && o_waitrequest) begin
            case (i_address)
                CONFIG_OFFSET: o_readdata <= {21'h0, config_reg};
                STATUS_OFFSET: begin
                    o_readdata <= {21'h0, fail_mask, violation, mismatch, done, state != ST_IDLE};
                end
                default: o_readdata <= 32'h0;
            endcase
        end
    end

    // config is frozen while a sequence runs so written and compared words agree
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_take && i_address == CONFIG_OFFSET && state == ST_IDLE) begin
            if (i_byteenable[0]) begin
                config_reg[7:0] <= i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                config_reg[CFG_WIDTH-1:8] <= i_writedata[CFG_WIDTH-1:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: write all device registers, then read each back
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            idx <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_cmd) begin
                        state <= ST_WR;
                        idx <= 3'h0;
                    end
                end
                ST_WR: begin
                    if (i_dev_ack) begin
                        idx <= (idx == 3'(DEV_REGS - 1)) ? 3'h0 : idx + 3'h1;
                        if (idx == 3'(DEV_REGS - 1)) begin
                            state <= ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    if (i_dev_ack) begin
                        idx <= (idx == 3'(DEV_REGS - 1)) ? 3'h0 : idx + 3'h1;
                        if (idx == 3'(DEV_REGS - 1)) begin
                            state <= ST_FIN;
                        end
                    end
                end
                ST_FIN: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // device port: request held with address and data until the ack edge
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_dev_req <= 1'b0;
            o_dev_write <= 1'b0;
            o_dev_addr <= 3'h0;
            o_dev_wdata <= 32'h0;
        end else if (start_cmd) begin
            o_dev_req <= 1'b1;
            o_dev_write <= 1'b1;
            o_dev_addr <= 3'h0;
            o_dev_wdata <= dev_word(3'h0, config_reg);
        end else if (o_dev_req && i_dev_ack) begin
            if (state == ST_RD && idx == 3'(DEV_REGS - 1)) begin
                o_dev_req <= 1'b0;
                o_dev_write <= 1'b0;
                o_dev_wdata <= 32'h0;
            end else if (state == ST_WR && idx == 3'(DEV_REGS - 1)) begin
                o_dev_write <= 1'b0;
                o_dev_addr <= 3'h0;
                o_dev_wdata <= 32'h0;
            end else begin
                o_dev_addr <= idx + 3'h1;
                o_dev_wdata <= (state == ST_WR) ? dev_word(idx + 3'h1, config_reg) : 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback verdicts
    lane_cfg_check u_check (
        .i_index(idx),
        .i_word(i_dev_rdata),
        .i_gear(gear),
        .i_sync_en_used(config_reg[CFG_SYNC_EN_BIT]),
        .o_ok(check_ok)
    );

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mismatch <= 1'b0;
            violation <= 1'b0;
            fail_mask <= '0;
        end else if (start_cmd) begin
            mismatch <= 1'b0;
            violation <= 1'b0;
            fail_mask <= '0;
        end else if (state == ST_RD && i_dev_ack) begin
            if (i_dev_rdata != dev_word(idx, config_reg)) begin
                mismatch <= 1'b1;
                fail_mask[idx] <= 1'b1;
            end
            if (!check_ok) begin
                violation <= 1'b1;
                fail_mask[idx] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done <= 1'b0;
        end else if (state == ST_FIN) begin
            done <= 1'b1;
        end else if (start_cmd) begin
            done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence dev_wr_at(logic [2:0] a);
        o_dev_req && o_dev_write && o_dev_addr == a;
    endsequence

    sequence dev_wait;
        o_dev_req && !i_dev_ack;
    endsequence

    sequence dev_taken;
        o_dev_req && i_dev_ack;
    endsequence

    sequence dev_rd_at(logic [2:0] a);
        o_dev_req && !o_dev_write && o_dev_addr == a;
    endsequence

    sequence avl_seen;
        (i_read || i_write) && o_waitrequest;
    endsequence

    path_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_OVERLAY_PATH_SELECT) |-> o_dev_wdata[FABRIC_PATH_LSB +: 4] == 4'h4)
        else $error("overlay path not written as 8b10b");
    coding_clk_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_CLOCK_SOURCE_SELECT) |-> o_dev_wdata[CODING_RX_SRC_LSB +: 2] == 2'h3
            && o_dev_wdata[CODING_TX_SRC_LSB +: 2] == 2'h3)
        else $error("coding clock sources not three");
    fifo_gear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_CLOCK_SOURCE_SELECT) |-> o_dev_wdata[RXF_WR_SRC_LSB +: 2] == gear
            && o_dev_wdata[TXF_RD_SRC_LSB +: 2] == gear && !o_dev_wdata[RXF_SIDE_BIT])
        else $error("fifo clock sources disagree with gear");
    clock_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_CLOCK_ENABLES) |-> o_dev_wdata[3:0] == 4'hf)
        else $error("clock enables not all set");
    serdes_width_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (dev_wr_at(DEV_DESERIALIZER_WIDTH_CONTROL) or dev_wr_at(DEV_SERIALIZER_WIDTH_CONTROL))
            |-> o_dev_wdata[WIDTH_LSB +: 3] == 3'h7)
        else $error("serdes width not 40 bit");
    slip_ctrl_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_RECOVERY_SLIP_CONTROL) |-> o_dev_wdata[1:0] == 2'b10)
        else $error("slip control word wrong");
    gear_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_ENCODER_LANE_CONFIG) |-> o_dev_wdata[GEAR_LSB +: 2] == gear)
        else $error("gear field differs from config");
    req_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wait |=> $stable(o_dev_addr) && $stable(o_dev_write) && $stable(o_dev_wdata) && o_dev_req)
        else $error("device request changed before ack");
    violation_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state == ST_RD && i_dev_ack && !check_ok |=> violation ##1 (violation && (done || state != ST_IDLE)))
        else $error("violation not flagged");
    avl_answer_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
        else $error("avalon answer not one cycle");

    ////////////////////////////////////////////////////////////////////////
    // sequencer order and flag lifetime; a stuck index would rewrite one register forever
    start_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        start_cmd |=> dev_wr_at(DEV_ENCODER_LANE_CONFIG) ##0 (!done && !mismatch && !violation && fail_mask == '0))
        else $error("start did not clear flags and open the write pass");
    dev_advance_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_taken ##0 o_dev_addr != 3'(DEV_REGS - 1) |=> o_dev_req && o_dev_write == $past(o_dev_write)
            && o_dev_addr == $past(o_dev_addr) + 3'h1)
        else $error("device index did not advance by one");
    pass_turn_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_taken ##0 dev_wr_at(3'(DEV_REGS - 1)) |=> dev_rd_at(DEV_ENCODER_LANE_CONFIG) ##0 o_dev_wdata == 32'h0)
        else $error("read pass did not follow the last write");
    dev_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_taken ##0 dev_rd_at(3'(DEV_REGS - 1)) |=> !o_dev_req ##1 (done && state == ST_IDLE))
        else $error("sequence did not end after the last read");
    idle_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state == ST_IDLE |-> !o_dev_req)
        else $error("device request while idle");
    index_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_dev_req |-> o_dev_addr < 3'(DEV_REGS))
        else $error("device index out of range");
    read_word_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_dev_req && !o_dev_write |-> o_dev_wdata == 32'h0)
        else $error("write data not zero during a read");
    fab_clk_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_CLOCK_SOURCE_SELECT)
            |-> o_dev_wdata[FAB_RX_CLK_LSB +: 2] == config_reg[CFG_FAB_RX_LSB +: 2]
            && o_dev_wdata[FAB_TX_CLK_LSB +: 2] == config_reg[CFG_FAB_TX_LSB +: 2])
        else $error("fabric clock selects differ from config");
    serlane_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        dev_wr_at(DEV_LANE_OVERLAY_PATH_SELECT)
            |-> o_dev_wdata[SERLANE_PATH_LSB +: 4] == config_reg[CFG_SERPATH_LSB +: 4])
        else $error("serializer lane path differs from config");
    ////////////////////////////////////////////////////////////////////////
    // register side
    config_freeze_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state != ST_IDLE |=> $stable(config_reg))
        else $error("config changed during a sequence");
    config_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        avl_seen ##0 (i_read && i_address == CONFIG_OFFSET) |=> o_readdata == {21'h0, $past(config_reg)})
        else $error("config read back wrong");
    status_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        avl_seen ##0 (i_read && i_address == STATUS_OFFSET) |=> o_readdata[ST_DONE_BIT] == $past(done))
        else $error("status done bit read back wrong");
    ctrl_read_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        avl_seen ##0 (i_read && i_address == CTRL_OFFSET) |=> o_readdata == 32'h0)
        else $error("control register read not zero");
    readdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !i_read |=> $stable(o_readdata))
        else $error("read data moved without a read");
    avl_rest_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !(i_read || i_write) && o_waitrequest |=> o_waitrequest)
        else $error("waitrequest dropped without a request");
    done_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        done |-> state == ST_IDLE)
        else $error("done while sequence runs");
    flag_mask_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        fail_mask == '0 |-> !mismatch && !violation)
        else $error("flag raised without a failing index");
endmodule

// *** hw/lane_cfg_pkg.sv ***
// constants shared by the 8b10b lane configuration controller and its checker
package lane_cfg_pkg;
    ////////////////////////////////////////////////////////////////////////
    // controller registers, byte offsets on the avalon side
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] CONFIG_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam int CTRL_START_BIT = 0;
    localparam int CFG_GEAR_LSB = 0;
    localparam int CFG_FAB_RX_LSB = 2;
    localparam int CFG_FAB_TX_LSB = 4;
    localparam int CFG_SERPATH_LSB = 6;
    localparam int CFG_SYNC_EN_BIT = 10;
    localparam int CFG_WIDTH = 11;
    localparam logic [10:0] CONFIG_RESET = 11'h014;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_MISMATCH_BIT = 2;
    localparam int ST_VIOLATION_BIT = 3;
    localparam int ST_FAIL_LSB = 4;
    ////////////////////////////////////////////////////////////////////////
    // device register indices on the device access port
    localparam int DEV_REGS = 7;
    localparam logic [2:0] DEV_ENCODER_LANE_CONFIG = 3'h0;
    localparam logic [2:0] DEV_LANE_OVERLAY_PATH_SELECT = 3'h1;
    localparam logic [2:0] DEV_LANE_CLOCK_SOURCE_SELECT = 3'h2;
    localparam logic [2:0] DEV_LANE_CLOCK_ENABLES = 3'h3;
    localparam logic [2:0] DEV_DESERIALIZER_WIDTH_CONTROL = 3'h4;
    localparam logic [2:0] DEV_SERIALIZER_WIDTH_CONTROL = 3'h5;
    localparam logic [2:0] DEV_RECOVERY_SLIP_CONTROL = 3'h6;
    ////////////////////////////////////////////////////////////////////////
    // device field positions
    localparam int GEAR_LSB = 0;
    localparam int FABRIC_PATH_LSB = 0;
    localparam int SERLANE_PATH_LSB = 4;
    localparam int FAB_RX_CLK_LSB = 0;
    localparam int FAB_TX_CLK_LSB = 2;
    localparam int CODING_RX_SRC_LSB = 4;
    localparam int CODING_TX_SRC_LSB = 6;
    localparam int RXF_WR_SRC_LSB = 8;
    localparam int TXF_RD_SRC_LSB = 10;
    localparam int RXF_SIDE_BIT = 12;
    localparam int WIDTH_LSB = 0;
    localparam int SLIP_SRC_BIT = 0;
    localparam int SLIP_EN_BIT = 1;
    ////////////////////////////////////////////////////////////////////////
    // required 8b10b values
    localparam logic [3:0] FABRIC_PATH_8B10B = 4'h4;
    localparam logic [1:0] FAB_CLK_NORMAL = 2'h1;
    localparam logic [1:0] CODING_CLK_SRC = 2'h3;
    localparam logic RXF_SIDE_8B10B = 1'b0;
    localparam logic [3:0] CLOCK_ENABLES_ALL = 4'hf;
    localparam logic [2:0] WIDTH_40BIT = 3'h7;
    localparam logic SLIP_SRC_FABRIC = 1'b0;
    localparam logic SLIP_EN_ON = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR = 3'b001,
        ST_RD = 3'b011,
        ST_FIN = 3'b010
    } seq_state_t;
endpackage

// *** hw/lane_cfg_check.sv ***
// judges one device register word against the 8b10b settings
module lane_cfg_check (
    input wire logic [2:0] i_index,
    input wire logic [31:0] i_word,
    input wire logic [1:0] i_gear,
    input wire logic i_sync_en_used,
    output logic o_ok
);
    import lane_cfg_pkg::*;

    always_comb begin
        case (i_index)
            DEV_ENCODER_LANE_CONFIG: o_ok = (i_word[GEAR_LSB +: 2] == i_gear);
            DEV_LANE_OVERLAY_PATH_SELECT: o_ok = (i_word[FABRIC_PATH_LSB +: 4] == FABRIC_PATH_8B10B);
            DEV_LANE_CLOCK_SOURCE_SELECT: begin
                // fabric clocks may differ only when the rx fifo sync enable is in use
                o_ok = (i_sync_en_used || (i_word[FAB_RX_CLK_LSB +: 2] == FAB_CLK_NORMAL
                        && i_word[FAB_TX_CLK_LSB +: 2] == FAB_CLK_NORMAL))
                    && i_word[CODING_RX_SRC_LSB +: 2] == CODING_CLK_SRC
                    && i_word[CODING_TX_SRC_LSB +: 2] == CODING_CLK_SRC
                    && i_word[RXF_WR_SRC_LSB +: 2] == i_gear
                    && i_word[TXF_RD_SRC_LSB +: 2] == i_gear
                    && i_word[RXF_SIDE_BIT] == RXF_SIDE_8B10B;
            end
            DEV_LANE_CLOCK_ENABLES: o_ok = (i_word[3:0] == CLOCK_ENABLES_ALL);
            DEV_DESERIALIZER_WIDTH_CONTROL,
            DEV_SERIALIZER_WIDTH_CONTROL: o_ok = (i_word[WIDTH_LSB +: 3] == WIDTH_40BIT);
            DEV_RECOVERY_SLIP_CONTROL: begin
                o_ok = (i_word[SLIP_SRC_BIT] == SLIP_SRC_FABRIC) && (i_word[SLIP_EN_BIT] == SLIP_EN_ON);
            end
            default: o_ok = 1'b0;
        endcase
    end
endmodule

// *** bench/lane_dev_model.sv ***
// behavioural lane device: seven configuration words behind a req/ack port
module lane_dev_model
    import lane_cfg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [2:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [2:0] i_delay,
    input wire logic i_corrupt_en,
    input wire logic [2:0] i_corrupt_idx,
    output logic [3:0] o_octets_per_beat,
    output logic [31:0] o_rdata,
    output logic o_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [DEV_REGS];
    logic [2:0] wait_cnt;
    logic [31:0] last;
    wire logic [1:0] stored_gear = mem[3'h0][1:0];
    // octets per fabric beat follow the stored gear; code three is treated as unsupported
    assign o_octets_per_beat = (stored_gear == 2'h3) ? 4'h0 : 4'h2 << stored_gear;
    ////////////////////////////////////////////////////////////////////////
    // delay of zero answers in the cycle the request appears
    assign o_ack = i_req && (wait_cnt == i_delay);
    // outside a read answer the bus shows the inverse of the last word, never a stale copy
    assign o_rdata = (o_ack && !i_write) ? (mem[i_addr] ^ {31'h0, i_corrupt_en && (i_addr == i_corrupt_idx)})
                                         : ~last;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_cnt <= 3'h0;
            last <= 32'h0;
        end else if (o_ack) begin
            wait_cnt <= 3'h0;
            if (!i_write) begin
                last <= o_rdata;
            end
        end else if (i_req) begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // stored settings steer only the octets per beat, through the gear held in word 0
    always_ff @(posedge i_ref_clk) begin
        if (o_ack && i_write) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule

// *** bench/lane_8b10b_mode_config_tb.sv ***
// self-checking bench for the 8b10b lane configuration controller
module lane_8b10b_mode_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lane_cfg_pkg::*;
    logic clk, nrst, rd, wr, dev_ack, dev_req, dev_write, corrupt_en, waitreq;
    logic [3:0] address, be, octets;
    logic [31:0] wdata, readdata, dev_wdata, dev_rdata, seed, q, r;
    logic [2:0] dev_addr, delay, corrupt_idx;
    logic [10:0] cfg;
    logic [35:0] trace[$];
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    lane_8b10b_mode_config uut (.i_ref_clk(clk), .i_nrst(nrst), .i_address(address), .i_read(rd), .i_write(wr),
        .i_writedata(wdata), .i_byteenable(be), .o_readdata(readdata), .o_waitrequest(waitreq),
        .o_dev_req(dev_req), .o_dev_write(dev_write), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata),
        .i_dev_rdata(dev_rdata), .i_dev_ack(dev_ack));
    lane_dev_model dev_model (.i_ref_clk(clk), .i_nrst(nrst), .i_req(dev_req), .i_write(dev_write),
        .i_addr(dev_addr), .i_wdata(dev_wdata), .i_delay(delay), .i_corrupt_en(corrupt_en),
        .i_corrupt_idx(corrupt_idx), .o_octets_per_beat(octets), .o_rdata(dev_rdata), .o_ack(dev_ack));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nrst === 1'b1 && dev_req === 1'b1 && dev_ack === 1'b1) begin
            trace.push_back({dev_write, dev_addr, dev_wdata});
        end
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rng();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] dev_word(input logic [10:0] c, input int i);
        case (i)
            0: return {30'h0, c[1:0]};
            1: return {24'h0, c[9:6], FABRIC_PATH_8B10B};
            2: return {19'h0, RXF_SIDE_8B10B, c[1:0], c[1:0], CODING_CLK_SRC, CODING_CLK_SRC, c[5:4], c[3:2]};
            3: return {28'h0, CLOCK_ENABLES_ALL};
            4, 5: return {29'h0, WIDTH_40BIT};
            default: return {30'h0, SLIP_EN_ON, SLIP_SRC_FABRIC};
        endcase
    endfunction
    // corrupted indices hold required fields in bit 0, so they violate as well as mismatch
    function automatic logic [31:0] exp_status(input logic [10:0] c, input logic ce, input logic [2:0] ci);
        logic v;
        logic [6:0] m;
        v = (c[3:2] != FAB_CLK_NORMAL || c[5:4] != FAB_CLK_NORMAL) && !c[10];
        m = v ? 7'h04 : 7'h00;
        if (ce) begin
            m[ci] = 1'b1;
        end
        return {21'h0, m, v || ce, ce, 2'b10};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] data);
        @(posedge clk);
        address <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        // only the global cycle ceiling ends a wait that never answers
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        data = readdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [10:0] c);
        int n;
        logic [35:0] e;
        av(1'b1, CONFIG_OFFSET, {21'h0, c}, 4'hf, q);
        trace.delete();
        av(1'b1, CTRL_OFFSET, 32'h1, 4'h1, q);
        av(1'b1, CONFIG_OFFSET, {21'h0, ~c}, 4'hf, q);
        av(1'b0, STATUS_OFFSET, 32'h0, 4'hf, q);
        check("busy status", {34'h0, q[1:0]}, 36'h1);
        n = 0;
        while (q[0] !== 1'b0 && n < 200) begin
            av(1'b0, STATUS_OFFSET, 32'h0, 4'hf, q);
            n++;
        end
        check("final status", {4'h0, q}, {4'h0, exp_status(c, corrupt_en, corrupt_idx)});
        av(1'b0, CONFIG_OFFSET, 32'h0, 4'hf, q);
        check("config kept", {4'h0, q}, {25'h0, c});
        check("octets per beat", {32'h0, octets}, {32'h0, (c[1:0] == 2'h3) ? 4'h0 : 4'h2 << c[1:0]});
        check("trace length", 36'(trace.size()), 36'd14);
        for (int i = 0; i < 14 && i < trace.size(); i++) begin
            e = {i < 7, 3'(i % 7), i < 7 ? dev_word(c, i % 7) : 32'h0};
            check("device access", trace[i], e);
        end
    endtask
    initial begin
        nrst = 1'b0;
        {rd, wr, corrupt_en} = 3'b000;
        {address, be, delay, corrupt_idx} = 14'h0;
        wdata = 32'h0;
        seed = 32'hd8513a36;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        av(1'b0, CONFIG_OFFSET, 32'h0, 4'hf, q);
        check("config reset", {4'h0, q}, {25'h0, CONFIG_RESET});
        av(1'b0, STATUS_OFFSET, 32'h0, 4'hf, q);
        check("status reset", {4'h0, q}, 36'h0);
        av(1'b1, 4'hc, 32'hffffffff, 4'hf, q);
        av(1'b0, 4'hc, 32'h0, 4'hf, q);
        check("unmapped read", {4'h0, q}, 36'h0);
        av(1'b1, CONFIG_OFFSET, 32'h000007ff, 4'h2, q);
        av(1'b0, CONFIG_OFFSET, 32'h0, 4'hf, q);
        check("byte lane write", {4'h0, q}, 36'h714);
        av(1'b0, CTRL_OFFSET, 32'h0, 4'hf, q);
        check("ctrl read", {4'h0, q}, 36'h0);
        for (int it = 0; it < 14; it++) begin
            r = rng();
            case (it)
                0: cfg = 11'h014;
                1: cfg = 11'h018;
                2: cfg = 11'h404;
                default: cfg = r[11] ? {r[10:6], 4'b0101, r[1:0]} : r[10:0];
            endcase
            delay <= (it == 1) ? 3'h7 : (it == 0 ? 3'h0 : r[14:12]);
            corrupt_en <= (it == 2) || (it > 2 && r[17:16] == 2'b00);
            corrupt_idx <= 3'h3 + 3'(r[19:18] % 3);
            run(cfg);
        end
        end_of_test();
    end
endmodule
